// ---- core/sysctl_pkg.sv ----
// Purpose: Constants for the sensor enable and power-on reset disable slice
// Assumes: 32-bit AXI4-Lite register access, byte addresses as printed
// Notes: Unlock register lives in this slice at the system control offset
package sysctl_pkg;
  localparam logic [11:0] temp_sensor_ctrl_off = 12'h01C;
  localparam logic [11:0] poweron_reset_ctrl_off = 12'h024;
  localparam logic [11:0] write_protect_unlock_off = 12'h100;
  localparam int sensor_enable_bit = 0;
  localparam logic sensor_enable_rst = 1'h0;
  localparam logic [15:0] reset_disable_key_val = 16'h5AA5;
  localparam logic [15:0] reset_disable_key_rst = 16'h0000;
  localparam logic [7:0] unlock_step0 = 8'h59;
  localparam logic [7:0] unlock_step1 = 8'h16;
  localparam logic [7:0] unlock_step2 = 8'h88;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  localparam logic [5:0] other_reset_count = 6'h06;
  typedef enum logic [1:0] {unlock_idle, unlock_got0, unlock_got1, unlock_open} unlock_state_t;
endpackage

// ---- core/reset_source_sync.sv ----
// Purpose: Brings asynchronous reset source levels into the clock domain
// Assumes: Each source is an active-high request level from outside
// Notes: Three flops; a change counts when the second and third agree
`timescale 1ns/1ps
module reset_source_sync
  import sysctl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw sources
  input wire logic [5:0] src_raw,
  // Qualified level
  output logic [5:0] src_level
);
  logic [5:0] stage1;
  logic [5:0] stage2;
  logic [5:0] stage3;
  logic [5:0] next_level;

  always_comb begin
    next_level = src_level;
    for (int i = 0; i < 6; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= 6'h00;
      stage2 <= 6'h00;
      stage3 <= 6'h00;
      src_level <= 6'h00;
    end else begin
      stage1 <= src_raw;
      stage2 <= stage1;
      stage3 <= stage2;
      src_level <= next_level;
    end
  end
endmodule

// ---- core/sysctl_regs.sv ----
// Purpose: Sensor enable and keyed power-on reset disable registers
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes: Key field is guarded by the three-byte unlock sequence
//
// Overview of operation
// - The sensor enable output follows bit 0 of the sensor control register.
// - The sensor enable bit is 0 after reset.
// - With the sensor on, converter channel 7 with the sensor input selected reads temperature.
// - At power-up the power-on reset circuit resets the whole chip.
// - The power-on reset circuit is disabled while the key field holds 0x5AA5.
// - Writing any other value to the key field re-arms power-on reset; here key writes take effect only while the unlock sequence is open.
// - Any other reset source acting re-arms power-on reset.
`timescale 1ns/1ps
module sysctl_regs
  import sysctl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Other reset sources: pin, watchdog, low voltage, brownout, debug, software
  input wire logic [5:0] other_reset_req,
  // Analog controls
  output logic sensor_enable,
  output logic poweron_reset_disable,
  output logic write_protect_open
);
  // Write path state
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [11:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  // Read path state
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  // Register state
  logic next_sensor_enable;
  logic [15:0] reset_disable_key;
  logic [15:0] next_reset_disable_key;
  logic next_por_disable;
  unlock_state_t unlock_state;
  unlock_state_t next_unlock_state;
  logic next_open;
  // Reset sources
  logic [5:0] src_level;
  logic [5:0] src_prev;
  logic other_reset_hit;
  logic do_write;

  reset_source_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_raw(other_reset_req),
    .src_level(src_level)
  );

  function automatic logic addr_mapped(input logic [11:0] a);
    return (a == temp_sensor_ctrl_off) || (a == poweron_reset_ctrl_off) ||
           (a == write_protect_unlock_off);
  endfunction

  // Word aligned address, shared by the write and read paths
  function automatic logic [11:0] word_addr(input logic [11:0] a);
    return {a[11:2], 2'h0};
  endfunction

  // Byte lane merge for the key field
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  assign other_reset_hit = |(src_level & ~src_prev);
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Write channel handling
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'h1;
      next_aw_addr = word_addr(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'h1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'h0;
      next_w_held = 1'h0;
      next_bvalid = 1'h1;
      if (addr_mapped(aw_addr)) begin
        next_bresp = resp_okay;
      end else begin
        next_bresp = resp_slverr;
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'h0;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  // Unlock sequence; any wrong byte falls back to locked
  always_comb begin
    next_unlock_state = unlock_state;
    if (do_write && aw_addr == write_protect_unlock_off && w_strb[0]) begin
      unique case (unlock_state)
        unlock_idle: begin
          if (w_data[7:0] == unlock_step0) begin
            next_unlock_state = unlock_got0;
          end else begin
            next_unlock_state = unlock_idle;
          end
        end
        unlock_got0: begin
          if (w_data[7:0] == unlock_step1) begin
            next_unlock_state = unlock_got1;
          end else begin
            next_unlock_state = unlock_idle;
          end
        end
        unlock_got1: begin
          if (w_data[7:0] == unlock_step2) begin
            next_unlock_state = unlock_open;
          end else begin
            next_unlock_state = unlock_idle;
          end
        end
        unlock_open: begin
          if (w_data[7:0] == unlock_step0) begin
            next_unlock_state = unlock_open;
          end else begin
            next_unlock_state = unlock_idle;
          end
        end
      endcase
    end
    if (other_reset_hit) begin
      next_unlock_state = unlock_idle;
    end
    next_open = (next_unlock_state == unlock_open);
  end

  // Sensor bit and key field
  always_comb begin
    next_sensor_enable = sensor_enable;
    next_reset_disable_key = reset_disable_key;
    if (do_write && aw_addr == temp_sensor_ctrl_off && w_strb[0]) begin
      next_sensor_enable = w_data[sensor_enable_bit];
    end
    if (do_write && aw_addr == poweron_reset_ctrl_off && unlock_state == unlock_open) begin
      next_reset_disable_key = merge16(reset_disable_key, w_data, w_strb);
    end
    if (other_reset_hit) begin
      next_reset_disable_key = reset_disable_key_rst;
    end
    next_por_disable = (next_reset_disable_key == reset_disable_key_val);
  end

  // Read channel handling
  always_comb begin
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (!s_axi_arready && !s_axi_rvalid) begin
      next_arready = 1'h1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'h0;
      next_rvalid = 1'h1;
      next_rresp = resp_okay;
      next_rdata = 32'h00000000;
      unique case (word_addr(s_axi_araddr))
        temp_sensor_ctrl_off: begin
          next_rdata = {31'h00000000, sensor_enable};
        end
        poweron_reset_ctrl_off: begin
          next_rdata = {16'h0000, reset_disable_key};
        end
        write_protect_unlock_off: begin
          next_rdata = {31'h00000000, write_protect_open};
        end
        default: begin
          next_rresp = resp_slverr;
        end
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'h0;
      next_arready = 1'h1;
    end
  end

  // Write path registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'h0;
      w_held <= 1'h0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'h0;
      s_axi_wready <= 1'h0;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= resp_okay;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // Read path registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= resp_okay;
    end else begin
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sensor_enable <= sensor_enable_rst;
      reset_disable_key <= reset_disable_key_rst;
      poweron_reset_disable <= 1'h0;
      unlock_state <= unlock_idle;
      write_protect_open <= 1'h0;
      src_prev <= 6'h00;
    end else begin
      sensor_enable <= next_sensor_enable;
      reset_disable_key <= next_reset_disable_key;
      poweron_reset_disable <= next_por_disable;
      unlock_state <= next_unlock_state;
      write_protect_open <= next_open;
      src_prev <= src_level;
    end
  end
endmodule

// ---- test/sysctl_regs_sva.sv ----
// Purpose: Bus and control checks for the sensor and reset disable slice
// Assumes: Sees only the ports of sysctl_regs
// Notes: One clock domain, so default clocking and disable are used
`timescale 1ns/1ps
module sysctl_regs_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Controls
  input wire logic [5:0] other_reset_req,
  input wire logic poweron_reset_disable,
  input wire logic write_protect_open
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence src_edge;
    (other_reset_req & ~$past(other_reset_req)) != 6'h00;
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  chk_refuse_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_source_relock: assert property (src_edge |-> ##[1:6]
    (!poweron_reset_disable && !write_protect_open)) else $error("source did not relock");
  chk_key_unlocked: assert property ($rose(poweron_reset_disable) |->
    $rose(s_axi_bvalid) && $past(write_protect_open)) else $error("key taken while locked");
  chk_open_cause: assert property ($rose(write_protect_open) |-> $rose(s_axi_bvalid))
    else $error("unlock without a write");
endmodule
bind sysctl_regs sysctl_regs_sva chk (.*);

// ---- test/por_disable_and_temp_sensor_ctrl_tb.sv ----
// Purpose: Self-checking bench for the sensor and reset disable slice
// Assumes: AXI4-Lite master driven at rising edges
// Notes: Random data from a fixed seed among hand-picked cases
`timescale 1ns/1ps
module por_disable_and_temp_sensor_ctrl_tb import sysctl_pkg::*; ();
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [5:0] other_reset_req = 6'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic sensor_enable, poweron_reset_disable, write_protect_open;
  integer seed = 32'h2E4A7A04, num_errors = 0, comparisons = 0, cyc = 0;
  logic [15:0] key = 16'h0000;
  sysctl_regs uut (.*);
  initial forever #25 aclk = ~aclk;
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      conclude();
    end
  end
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'h1) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready === 1'h1) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ev, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    check("rdata", s_axi_rdata, ev);
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic ul(input logic [7:0] b);
    wr(write_protect_unlock_off, {24'h0, b}, 4'hF, resp_okay);
  endtask
  function automatic logic [15:0] key_merge(input logic [15:0] old, input logic [31:0] v,
                                            input logic [3:0] s);
    key_merge = {s[1] ? v[15:8] : old[15:8], s[0] ? v[7:0] : old[7:0]};
  endfunction
  function automatic logic [31:0] w1(input logic b);
    w1 = {31'h0, b};
  endfunction
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check("sensor", w1(sensor_enable), 32'h0);
    check("disable", w1(poweron_reset_disable), 32'h0);
    rd(temp_sensor_ctrl_off, 32'h0, resp_okay);
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 32'hFFFFFFFF : $random(seed);
      wr(temp_sensor_ctrl_off, d, 4'hF, resp_okay);
      check("sensor", w1(sensor_enable), {31'h0, d[0]});
      wr(temp_sensor_ctrl_off, ~d, 4'hE, resp_okay);
      rd(temp_sensor_ctrl_off, {31'h0, d[0]}, resp_okay);
    end
    wr(12'h020, $random(seed), 4'hF, resp_slverr);
    rd(12'h020, 32'h0, resp_slverr);
    wr(poweron_reset_ctrl_off, {16'h0, reset_disable_key_val}, 4'hF, resp_okay);
    check("disable", w1(poweron_reset_disable), 32'h0);
    rd(poweron_reset_ctrl_off, 32'h0, resp_okay);
    ul(unlock_step0);
    ul(unlock_step2);
    check("open", w1(write_protect_open), 32'h0);
    for (int k = 0; k < 6; k++) begin
      ul(unlock_step0);
      ul(unlock_step1);
      ul(unlock_step2);
      check("open", w1(write_protect_open), 32'h1);
      rd(write_protect_unlock_off, 32'h1, resp_okay);
      d = $random(seed);
      d[15:0] = reset_disable_key_val ^ (16'h0001 << k);
      wr(poweron_reset_ctrl_off, d, 4'h3, resp_okay);
      key = d[15:0];
      check("disable", w1(poweron_reset_disable), 32'h0);
      rd(poweron_reset_ctrl_off, {16'h0, key}, resp_okay);
      d = $random(seed);
      wr(poweron_reset_ctrl_off, d, 4'h1, resp_okay);
      key = key_merge(key, d, 4'h1);
      check("disable", w1(poweron_reset_disable), {31'h0, key == reset_disable_key_val});
      rd(poweron_reset_ctrl_off, {16'h0, key}, resp_okay);
      ul(unlock_step0);
      check("open", w1(write_protect_open), 32'h1);
      wr(poweron_reset_ctrl_off, {d[31:16], reset_disable_key_val}, 4'h3, resp_okay);
      check("disable", w1(poweron_reset_disable), 32'h1);
      rd(poweron_reset_ctrl_off, {16'h0, reset_disable_key_val}, resp_okay);
      if (k % 2 == 1) begin
        ul(8'h00);
        check("open", w1(write_protect_open), 32'h0);
        wr(poweron_reset_ctrl_off, 32'h00000000, 4'hF, resp_okay);
        check("disable", w1(poweron_reset_disable), 32'h1);
        rd(poweron_reset_ctrl_off, {16'h0, reset_disable_key_val}, resp_okay);
      end
      other_reset_req <= 6'h01 << k;
      repeat (8) @(posedge aclk);
      check("disable", w1(poweron_reset_disable), 32'h0);
      check("open", w1(write_protect_open), 32'h0);
      other_reset_req <= 6'h00;
      repeat (6) @(posedge aclk);
    end
    ul(unlock_step0);
    ul(unlock_step1);
    ul(unlock_step2);
    wr(poweron_reset_ctrl_off, {16'h0, reset_disable_key_val}, 4'hF, resp_okay);
    check("disable", w1(poweron_reset_disable), 32'h1);
    wr(temp_sensor_ctrl_off, 32'h1, 4'hF, resp_okay);
    check("sensor", w1(sensor_enable), 32'h1);
    aresetn <= 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check("sensor", w1(sensor_enable), 32'h0);
    check("disable", w1(poweron_reset_disable), 32'h0);
    check("open", w1(write_protect_open), 32'h0);
    rd(poweron_reset_ctrl_off, 32'h0, resp_okay);
    conclude();
  end
endmodule
